// >>> design/isa_pkg.sv
// package: register map, field positions and reset values of the interrupt status block
package isa_pkg;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned EVT_W      = 20;
  localparam int unsigned RAW_W      = 18;
  localparam int unsigned TRK_W      = 19;
  localparam int unsigned CTL_W      = 5;
  localparam int unsigned GPIO_W     = 3;

  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_MASK    = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h108;
  localparam logic [ADDR_W-1:0] OFS_RAW     = 12'h10c;
  localparam logic [ADDR_W-1:0] OFS_CLEAR   = 12'h110;

  localparam logic [CTL_W-1:0]  CONTROL_RST = 5'h00;
  localparam logic [EVT_W-1:0]  MASK_RST    = 20'h00000;
  localparam logic [EVT_W-1:0]  STATUS_RST  = 20'h00000;
  localparam logic [DATA_W-1:0] READ_ZERO   = 32'h00000000;

  localparam int unsigned CTL_ENABLE   = 0;
  localparam int unsigned CTL_POLARITY = 1;
  localparam int unsigned CTL_GPIO_POL = 2;

  localparam int unsigned EV_VSYNC_RISE = 0;
  localparam int unsigned EV_VSYNC_FALL = 1;
  localparam int unsigned EV_VDE_RISE   = 2;
  localparam int unsigned EV_VDE_FALL   = 3;
  localparam int unsigned EV_ABORT      = 4;
  localparam int unsigned EV_GPIO       = 5;
  localparam int unsigned EV_CMD_HALF   = 8;
  localparam int unsigned EV_CMD_EMPTY  = 9;
  localparam int unsigned EV_SRC_HALF   = 10;
  localparam int unsigned EV_SRC_EMPTY  = 11;
  localparam int unsigned EV_ENG_IDLE   = 12;
  localparam int unsigned EV_UH_SUSP    = 13;
  localparam int unsigned EV_UH_WAKE    = 14;
  localparam int unsigned EV_UH_OHCI    = 15;
  localparam int unsigned EV_UD_INT     = 16;
  localparam int unsigned EV_AUDIO      = 17;
  localparam int unsigned EV_SPI        = 18;
  localparam int unsigned EV_UD_WAKE    = 19;

  localparam int unsigned RW_VSYNC      = 0;
  localparam int unsigned RW_VDE        = 1;
  localparam int unsigned RW_SCC        = 2;
  localparam int unsigned RW_SPI        = 3;
  localparam int unsigned RW_GPIO       = 4;
  localparam int unsigned RW_RSVD       = 7;
  localparam int unsigned RW_ENG_BUSY   = 8;
  localparam int unsigned RW_SRC_EMPTY  = 9;
  localparam int unsigned RW_SRC_HALF   = 10;
  localparam int unsigned RW_CMD_EMPTY  = 11;
  localparam int unsigned RW_CMD_HALF   = 12;
  localparam int unsigned RW_UH_OHCI    = 13;
  localparam int unsigned RW_UH_SUSP    = 14;
  localparam int unsigned RW_UH_WAKE    = 15;
  localparam int unsigned RW_UD_INT     = 16;
  localparam int unsigned RW_UD_WAKE    = 17;
  localparam int unsigned TR_AUDIO      = 18;

  // event bits that exist only with the usb host controller, or only on the larger variant
  localparam logic [EVT_W-1:0] HOST_ONLY_MASK  = 20'h0e000;
  localparam logic [EVT_W-1:0] LARGE_ONLY_MASK = 20'h60000;
endpackage : isa_pkg

// >>> design/isa_lvl_if.sv
// interface: source levels in, registered levels and edge strobes out
interface isa_lvl_if;
  logic [isa_pkg::TRK_W-1:0] raw_in;
  logic [isa_pkg::TRK_W-1:0] level;
  logic [isa_pkg::TRK_W-1:0] rise;
  logic [isa_pkg::TRK_W-1:0] fall;
  modport tracker (input raw_in, output level, rise, fall);
  modport owner   (output raw_in, input level, rise, fall);
endinterface : isa_lvl_if

// >>> design/isa_edge_tracker.sv
// edge tracker: holds last source levels and flags rising and falling edges
module isa_edge_tracker
  import isa_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset,
  isa_lvl_if.tracker  lvl
);
  logic [TRK_W-1:0] level_r;
  logic [TRK_W-1:0] level_nxt;

  always_comb begin
    level_nxt = lvl.raw_in;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      level_r <= '0;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign lvl.level = level_r;
  assign lvl.rise  = lvl.raw_in & ~level_r;
  assign lvl.fall  = ~lvl.raw_in & level_r;
endmodule : isa_edge_tracker

// >>> design/isa_interrupt_status_aggregator.sv
// top: latched event status, raw level word, mask, control and interrupt pin over avalon-mm
module isa_interrupt_status_aggregator
#(
  parameter bit HOST_CTRL_PRESENT = 1'b1,
  parameter bit LARGE_VARIANT     = 1'b1
)
(
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic [isa_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [isa_pkg::DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [isa_pkg::DATA_W-1:0]   avs_readdata,
  output logic                              avs_waitrequest,
  output logic                              irq_out,
  input  wire logic                         vsync,
  input  wire logic                         vdisp_enable,
  input  wire logic                         bus_abort,
  input  wire logic [isa_pkg::GPIO_W-1:0]   gpio_pin,
  input  wire logic                         cmd_fifo_half_empty,
  input  wire logic                         cmd_fifo_empty,
  input  wire logic                         src_fifo_half_empty,
  input  wire logic                         src_fifo_empty,
  input  wire logic                         engine_busy,
  input  wire logic                         usb_host_suspend,
  input  wire logic                         usb_host_wakeup,
  input  wire logic                         usb_host_ohci,
  input  wire logic                         usb_dev_irq,
  input  wire logic                         usb_dev_wakeup,
  input  wire logic                         audio_serial_irq,
  input  wire logic                         spi_irq,
  input  wire logic                         serial_comm_controller_irq
);
  import isa_pkg::*;

  function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  isa_lvl_if lvl ();

  isa_edge_tracker u_tracker (
    .clock (clock),
    .reset (reset),
    .lvl   (lvl.tracker)
  );

  // pin synchroniser
  logic [GPIO_W-1:0] gpio_meta_r;
  logic [GPIO_W-1:0] gpio_meta_nxt;
  logic [GPIO_W-1:0] gpio_sync_r;
  logic [GPIO_W-1:0] gpio_sync_nxt;

  always_comb begin
    gpio_meta_nxt = gpio_pin;
    gpio_sync_nxt = gpio_meta_r;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gpio_meta_r <= '0;
      gpio_sync_r <= '0;
    end else begin
      gpio_meta_r <= gpio_meta_nxt;
      gpio_sync_r <= gpio_sync_nxt;
    end
  end

  // raw source word, bits 17:0 form the bit layout of the raw level register
  logic [TRK_W-1:0] raw_word;

  always_comb begin
    raw_word                        = '0;
    raw_word[RW_VSYNC]              = vsync;
    raw_word[RW_VDE]                = vdisp_enable;
    raw_word[RW_SCC]                = serial_comm_controller_irq;
    raw_word[RW_SPI]                = spi_irq;
    raw_word[RW_GPIO +: GPIO_W]     = gpio_sync_r;
    raw_word[RW_RSVD]               = 1'b0;
    raw_word[RW_ENG_BUSY]           = engine_busy;
    raw_word[RW_SRC_EMPTY]          = src_fifo_empty;
    raw_word[RW_SRC_HALF]           = src_fifo_half_empty;
    raw_word[RW_CMD_EMPTY]          = cmd_fifo_empty;
    raw_word[RW_CMD_HALF]           = cmd_fifo_half_empty;
    raw_word[RW_UH_OHCI]            = usb_host_ohci;
    raw_word[RW_UH_SUSP]            = usb_host_suspend;
    raw_word[RW_UH_WAKE]            = usb_host_wakeup;
    raw_word[RW_UD_INT]             = usb_dev_irq;
    raw_word[RW_UD_WAKE]            = usb_dev_wakeup;
    raw_word[TR_AUDIO]              = audio_serial_irq;
  end

  assign lvl.raw_in = raw_word;

  // register state
  logic [CTL_W-1:0]  control_r;
  logic [CTL_W-1:0]  control_nxt;
  logic [EVT_W-1:0]  mask_r;
  logic [EVT_W-1:0]  mask_nxt;
  logic [EVT_W-1:0]  status_r;
  logic [EVT_W-1:0]  status_nxt;
  logic [DATA_W-1:0] readdata_r;
  logic [DATA_W-1:0] readdata_nxt;
  logic              waitreq_r;
  logic              waitreq_nxt;
  logic              irq_r;
  logic              irq_nxt;

  logic [EVT_W-1:0]  event_set;
  logic [EVT_W-1:0]  clear_bits;
  logic [EVT_W-1:0]  present;
  logic [DATA_W-1:0] wdata_be;
  logic [DATA_W-1:0] be_mask;
  logic [GPIO_W-1:0] gpio_fire;
  logic              request;
  logic              commit;
  logic              any_pending;

  // level match per general purpose pin
  for (genvar g = 0; g < GPIO_W; g++) begin : g_pin_level
    assign gpio_fire[g] = ~(gpio_sync_r[g] ^ control_r[CTL_GPIO_POL + g]);
  end

  // event sources
  always_comb begin
    event_set                       = '0;
    event_set[EV_VSYNC_RISE]        = lvl.rise[RW_VSYNC];
    event_set[EV_VSYNC_FALL]        = lvl.fall[RW_VSYNC];
    event_set[EV_VDE_RISE]          = lvl.rise[RW_VDE];
    event_set[EV_VDE_FALL]          = lvl.fall[RW_VDE];
    event_set[EV_ABORT]             = bus_abort;
    event_set[EV_GPIO +: GPIO_W]    = gpio_fire;
    event_set[EV_CMD_HALF]          = lvl.rise[RW_CMD_HALF];
    event_set[EV_CMD_EMPTY]         = lvl.rise[RW_CMD_EMPTY];
    event_set[EV_SRC_HALF]          = lvl.rise[RW_SRC_HALF];
    event_set[EV_SRC_EMPTY]         = lvl.rise[RW_SRC_EMPTY];
    event_set[EV_ENG_IDLE]          = lvl.fall[RW_ENG_BUSY];
    event_set[EV_UH_SUSP]           = lvl.rise[RW_UH_SUSP];
    event_set[EV_UH_WAKE]           = lvl.rise[RW_UH_WAKE];
    event_set[EV_UH_OHCI]           = lvl.rise[RW_UH_OHCI];
    event_set[EV_UD_INT]            = lvl.rise[RW_UD_INT];
    event_set[EV_AUDIO]             = lvl.rise[TR_AUDIO];
    event_set[EV_SPI]               = lvl.rise[RW_SPI];
    event_set[EV_UD_WAKE]           = lvl.rise[RW_UD_WAKE];
  end

  // variant gating of event bits
  always_comb begin
    present = '1;
    if (!HOST_CTRL_PRESENT) begin
      present = present & ~HOST_ONLY_MASK;
    end
    if (!LARGE_VARIANT) begin
      present = present & ~LARGE_ONLY_MASK;
    end
  end

  // bus slave: one wait cycle, then the answer edge
  always_comb begin
    request  = avs_read | avs_write;
    commit   = request & ~waitreq_r;
    be_mask  = lane_mask(avs_byteenable);
    wdata_be = avs_writedata & be_mask;
    waitreq_nxt = ~(request & waitreq_r);
    readdata_nxt = readdata_r;
    // only a read reloads the data word, so it holds across writes
    if (avs_read & waitreq_r) begin
      case (avs_address)
        OFS_CONTROL: readdata_nxt = {{(DATA_W-CTL_W){1'b0}}, control_r};
        OFS_MASK:    readdata_nxt = {{(DATA_W-EVT_W){1'b0}}, mask_r};
        OFS_STATUS:  readdata_nxt = {{(DATA_W-EVT_W){1'b0}}, status_r};
        OFS_RAW:     readdata_nxt = {{(DATA_W-RAW_W){1'b0}}, lvl.level[RAW_W-1:0]};
        default:     readdata_nxt = READ_ZERO;
      endcase
    end
  end

  // control, mask and sticky status
  always_comb begin
    control_nxt = control_r;
    mask_nxt    = mask_r;
    clear_bits  = '0;
    if (commit && avs_write) begin
      case (avs_address)
        OFS_CONTROL: control_nxt = (control_r & ~be_mask[CTL_W-1:0]) | wdata_be[CTL_W-1:0];
        OFS_MASK:    mask_nxt    = (mask_r & ~be_mask[EVT_W-1:0]) | wdata_be[EVT_W-1:0];
        OFS_STATUS:  clear_bits  = wdata_be[EVT_W-1:0];
        OFS_CLEAR:   clear_bits  = wdata_be[EVT_W-1:0];
        default:     clear_bits  = '0;
      endcase
    end
    // a new event wins over a clear in the same cycle
    status_nxt = ((status_r & ~clear_bits) | event_set) & present;
  end

  // interrupt pin at the selected polarity
  always_comb begin
    any_pending = |(status_r & mask_r);
    if (control_r[CTL_ENABLE] && any_pending) begin
      irq_nxt = control_r[CTL_POLARITY];
    end else begin
      irq_nxt = ~control_r[CTL_POLARITY];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control_r  <= CONTROL_RST;
      mask_r     <= MASK_RST;
      status_r   <= STATUS_RST;
    end else begin
      control_r  <= control_nxt;
      mask_r     <= mask_nxt;
      status_r   <= status_nxt;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readdata_r <= READ_ZERO;
      waitreq_r  <= 1'b1;
    end else begin
      readdata_r <= readdata_nxt;
      waitreq_r  <= waitreq_nxt;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_r      <= 1'b1;
    end else begin
      irq_r      <= irq_nxt;
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign irq_out         = irq_r;
endmodule : isa_interrupt_status_aggregator

// >>> verification/isa_chk.sv
// checker: bus handshake and interrupt pin timing of the status block
module isa_chk
  import isa_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       reset,
  input wire logic [isa_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [isa_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [isa_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic                       irq_out,
  input wire logic                       bus_abort,
  input wire logic [isa_pkg::GPIO_W-1:0] gpio_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CTL_W-1:0] ctl_r, ctl_nxt;
  logic [EVT_W-1:0] msk_r, msk_nxt;
  logic             acc;
  assign acc = avs_write && !avs_waitrequest;
  always_comb begin
    ctl_nxt = ctl_r;
    msk_nxt = msk_r;
    if (acc && avs_address == OFS_CONTROL) ctl_nxt = avs_writedata[CTL_W-1:0];
    if (acc && avs_address == OFS_MASK) msk_nxt = avs_writedata[EVT_W-1:0];
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl_r <= CONTROL_RST;
      msk_r <= MASK_RST;
    end else begin
      ctl_r <= ctl_nxt;
      msk_r <= msk_nxt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer after request");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("waitrequest low too long");
  property p_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  property p_hold; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
  a_hold: assert property (p_hold) else $error("readdata changed without read");
  property p_unm; avs_read && avs_waitrequest && (avs_address < OFS_CONTROL || avs_address >= OFS_CLEAR)
    |=> avs_readdata == READ_ZERO; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_rst; $fell(reset) |-> avs_waitrequest && irq_out; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_off; (!ctl_r[0] || msk_r == '0) && $stable(ctl_r) && $stable(msk_r)
    |=> irq_out == !$past(ctl_r[1]); endproperty
  a_off: assert property (p_off) else $error("irq pin active while off");
  property p_abt; bus_abort && ctl_r[1:0] == 2'b11 && msk_r[EV_ABORT] |-> ##2 irq_out; endproperty
  a_abt: assert property (p_abt) else $error("abort did not raise irq");
  property p_gpi; (gpio_pin[0] == ctl_r[2] && ctl_r[1:0] == 2'b11 && msk_r[EV_GPIO])[*4] |=> irq_out; endproperty
  a_gpi: assert property (p_gpi) else $error("pin level did not raise irq");
endmodule : isa_chk

// >>> verification/isa_host.sv
// host cpu model: avalon-mm master for register reads and writes
module isa_host
  import isa_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       avs_waitrequest,
  output logic      [isa_pkg::ADDR_W-1:0] avs_address,
  output logic                            avs_read,
  output logic                            avs_write,
  output logic      [isa_pkg::DATA_W-1:0] avs_writedata,
  output logic      [3:0]                 avs_byteenable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] exp_q [$];
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask : w
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] b);
    @(posedge clock);
    avs_address <= a;
    avs_byteenable <= b;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask : xfer
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    xfer(1'b0, a, d, 4'hf);
  endtask : wr
  task automatic wrb(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] b);
    xfer(1'b0, a, d, b);
  endtask : wrb
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    xfer(1'b1, a, ~e, 4'hf);
  endtask : rd
endmodule : isa_host

// >>> verification/isa_interrupt_status_aggregator_bench.sv
// bench: register, event and interrupt pin checks of the status block
module isa_interrupt_status_aggregator_bench
  import isa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest, irq_out;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic [GPIO_W-1:0] gpio_pin = 3'h0;
  logic [15:0]       sv = 16'h0;
  logic [31:0]       lf = 32'hdd22;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cyc = 0;
  localparam logic [DATA_W-1:0] ST [16] = '{32'h3, 32'hc, 32'h10, 32'h100, 32'h200, 32'h400, 32'h800,
    32'h1000, 32'h2000, 32'h4000, 32'h8000, 32'h10000, 32'h20000, 32'h40000, 32'h80000, 32'h0};
  localparam logic [DATA_W-1:0] RW [16] = '{32'h1, 32'h2, 32'h0, 32'h1000, 32'h800, 32'h400, 32'h200,
    32'h100, 32'h4000, 32'h8000, 32'h2000, 32'h10000, 32'h0, 32'h8, 32'h20000, 32'h4};
  isa_host hst (.clock, .avs_waitrequest, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
  isa_interrupt_status_aggregator uut (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq_out, .vsync(sv[0]), .vdisp_enable(sv[1]),
    .bus_abort(sv[2]), .gpio_pin, .cmd_fifo_half_empty(sv[3]), .cmd_fifo_empty(sv[4]),
    .src_fifo_half_empty(sv[5]), .src_fifo_empty(sv[6]), .engine_busy(sv[7]), .usb_host_suspend(sv[8]),
    .usb_host_wakeup(sv[9]), .usb_host_ohci(sv[10]), .usb_dev_irq(sv[11]), .audio_serial_irq(sv[12]),
    .spi_irq(sv[13]), .usb_dev_wakeup(sv[14]), .serial_comm_controller_irq(sv[15]));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e, input string nm);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial forever #25 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      conclude();
    end
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, hst.exp_q.pop_front(), "avs_readdata");
  end
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    hst.rd(OFS_CONTROL, 32'h0);
    hst.rd(OFS_STATUS, 32'he0);
    hst.wr(OFS_RAW, '1);
    hst.rd(OFS_RAW, 32'h0);
    hst.rd(12'h200, 32'h0);
    hst.rd(OFS_CLEAR, 32'h0);
    hst.wr(OFS_CONTROL, 32'h1c);
    hst.wr(OFS_STATUS, 32'h0);
    hst.rd(OFS_STATUS, 32'he0);
    hst.wr(OFS_STATUS, 32'he0);
    hst.rd(OFS_STATUS, 32'h0);
    for (int k = 0; k < 16; k++) begin
      sv <= 16'h1 << k;
      hst.w(3);
      hst.rd(OFS_RAW, RW[k]);
      sv <= 16'h0;
      hst.w(3);
      hst.rd(OFS_STATUS, ST[k]);
      hst.wr(k[0] ? OFS_CLEAR : OFS_STATUS, ST[k]);
    end
    hst.rd(OFS_STATUS, 32'h0);
    sv[3] <= 1'b1;
    hst.w(3);
    hst.wrb(OFS_STATUS, 32'hffffffff, 4'hd);
    hst.rd(OFS_STATUS, 32'h100);
    hst.wrb(OFS_CLEAR, 32'hffffffff, 4'h2);
    sv[3] <= 1'b0;
    hst.rd(OFS_STATUS, 32'h0);
    repeat (3) begin
      lf = nx(lf);
      hst.wr(OFS_MASK, lf);
      hst.rd(OFS_MASK, {12'h0, lf[19:0]});
    end
    hst.wr(OFS_MASK, 32'h10);
    hst.wr(OFS_CONTROL, 32'h1f);
    sv[2] <= 1'b1;
    hst.w(1);
    sv[2] <= 1'b0;
    hst.w(4);
    chk(32'(irq_out), 32'h1, "irq_out");
    hst.wr(OFS_MASK, 32'h0);
    hst.w(3);
    chk(32'(irq_out), 32'h0, "irq_out");
    hst.wr(OFS_CONTROL, 32'h1d);
    hst.wr(OFS_MASK, 32'h10);
    hst.w(3);
    chk(32'(irq_out), 32'h0, "irq_out");
    hst.wr(OFS_CONTROL, 32'h1c);
    hst.w(3);
    chk(32'(irq_out), 32'h1, "irq_out");
    hst.wr(OFS_STATUS, 32'h10);
    hst.rd(OFS_STATUS, 32'h0);
    hst.wr(OFS_MASK, 32'he0);
    hst.wr(OFS_CONTROL, 32'h1f);
    gpio_pin <= 3'h7;
    hst.w(6);
    chk(32'(irq_out), 32'h1, "irq_out");
    hst.rd(OFS_STATUS, 32'he0);
    hst.rd(OFS_RAW, 32'h70);
    reset <= 1'b1;
    hst.w(2);
    reset <= 1'b0;
    hst.rd(OFS_CONTROL, 32'h0);
    conclude();
  end
endmodule : isa_interrupt_status_aggregator_bench
bind isa_interrupt_status_aggregator isa_chk u_chk (.clock, .reset, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .irq_out, .bus_abort, .gpio_pin);
